// ### src/pof_top.v
`include "pof_defs.vh"
`default_nettype none

// ------------------------------------------------------------
// output fifo
// ------------------------------------------------------------
module pof_fifo #(
  parameter WIDTH = 27,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge aclk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // pof_fifo

// Behaviour
// [R1] 4:4:4 gives luma and both chromas per pixel
// [R2] 4:2:2 halves chroma horizontally only
// [R3] 4:1:1 quarters chroma horizontally only
// [R4] narrower output drops surplus low bits
// [R5] wider output left-aligns sample, pads low bits
// [R6] maximum words 65472, 65520, 65532 by depth
// [R7] host stops acquisition before changing depth
// [R8] selector picks sensor or pipeline generator
// [R9] off choice disables the addressed generator
// [R10] sensor generator enabled only by sensor pattern
// [R11] increment pattern adds one per pixel, wraps
// [R12] varying sequence restarts at acquisition start
// [R13] pipeline pattern overrides sensor pattern
// [R14] later processing acts on pattern, sensor controls not
// [R15] host turns off auto exposure and gain
// [R16] real image only with both generators off
// [R17] mirror flips each line; crop after flip
// [R18] mirror updates reported mosaic order
// [R19] increment pattern restarts each frame
module pof_top #(
  parameter ADC_W  = 14,
  parameter MAX_W  = 1024,
  parameter IDX_W  = 10,
  parameter FIFO_D = 32,
  parameter FIFO_A = 5
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire [7:0]       s_axi_awaddr,
  input  wire             s_axi_awvalid,
  output wire             s_axi_awready,
  input  wire [31:0]      s_axi_wdata,
  input  wire [3:0]       s_axi_wstrb,
  input  wire             s_axi_wvalid,
  output wire             s_axi_wready,
  output reg  [1:0]       s_axi_bresp,
  output reg              s_axi_bvalid,
  input  wire             s_axi_bready,
  input  wire [7:0]       s_axi_araddr,
  input  wire             s_axi_arvalid,
  output wire             s_axi_arready,
  output reg  [31:0]      s_axi_rdata,
  output reg  [1:0]       s_axi_rresp,
  output reg              s_axi_rvalid,
  input  wire             s_axi_rready,
  input  wire             pix_valid,
  output wire             pix_ready,
  input  wire             pix_sof,
  input  wire             pix_eol,
  input  wire [ADC_W-1:0] pix_sample,
  input  wire [23:0]      pix_rgb,
  output wire             sensor_tp_enable,
  output wire             out_valid,
  input  wire             out_ready,
  output wire             out_sof,
  output wire             out_eol,
  output wire [24:0]      out_data
);
  localparam MEM_W = ADC_W + 24;
  localparam ST_FILL  = 1'b0;
  localparam ST_DRAIN = 1'b1;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer i;
    begin
      merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  // low-justified sample into a left-aligned 16-bit word
  function [15:0] left_align;
    input [ADC_W-1:0] s;
    input [1:0]       dep;
    begin
      case (dep)
        `POF_DEP_10: left_align = {s[9:0], 6'h00};
        `POF_DEP_12: left_align = {s[11:0], 4'h0};
        `POF_DEP_14: left_align = {s[13:0], 2'h0};
        default:     left_align = {s[11:0], 4'h0};
      endcase
    end
  endfunction

  // 8-bit grey widened to converter depth
  function [ADC_W-1:0] grey_to_raw;
    input [7:0] g;
    input [1:0] dep;
    begin
      case (dep)
        `POF_DEP_10: grey_to_raw = {{(ADC_W-10){1'b0}}, g, 2'h0};
        `POF_DEP_14: grey_to_raw = {g, 6'h00};
        default:     grey_to_raw = {{(ADC_W-12){1'b0}}, g, 4'h0};
      endcase
    end
  endfunction

  function [7:0] clip8;
    input signed [17:0] v;
    begin
      if (v < 0) begin
        clip8 = 8'h00;
      end else if (v > 18'sd255) begin
        clip8 = 8'hFF;
      end else begin
        clip8 = v[7:0];
      end
    end
  endfunction

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg  [31:0] ctrl_q;
  reg  [31:0] roi_q;
  reg         sel_q;
  reg  [1:0]  sens_ch_q;
  reg  [1:0]  pipe_ch_q;
  reg         aw_got_q;
  reg         w_got_q;
  reg  [7:0]  aw_addr_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg  [31:0] ctrl_d;
  reg  [31:0] rd_d;
  reg         rd_ok;
  wire        wr_go;
  wire [1:0]  wr_ch;
  wire        acq_en;
  wire        mirror_en;
  wire [2:0]  fmt;
  wire [1:0]  depth;
  wire [1:0]  rep_order;
  wire        sens_on;
  wire        pipe_on;
  reg         state_q;
  reg  [7:0]  frame_q;

  assign acq_en    = ctrl_q[`POF_CTRL_ACQ];
  assign mirror_en = ctrl_q[`POF_CTRL_MIRROR];
  assign fmt       = ctrl_q[`POF_CTRL_FMT_HI:`POF_CTRL_FMT_LO];
  assign depth     = ctrl_q[`POF_CTRL_DEP_HI:`POF_CTRL_DEP_LO];
  assign sens_on   = (sens_ch_q == `POF_PAT_SENSOR);
  assign pipe_on   = (pipe_ch_q != `POF_PAT_OFF);
  assign sensor_tp_enable = sens_on;
  // flipping left-right swaps the first two mosaic columns
  assign rep_order = ctrl_q[`POF_CTRL_ORD_HI:`POF_CTRL_ORD_LO]
                     ^ {1'b0, mirror_en};                      // [R18]

  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_got_q && w_got_q && !s_axi_bvalid;
  assign wr_ch = w_data_q[`POF_PAT_CH_HI:`POF_PAT_CH_LO];

  always @* begin
    ctrl_d = merge(ctrl_q, w_data_q, w_strb_q);
    // depth is frozen while acquisition runs
    if (acq_en) begin
      ctrl_d[`POF_CTRL_DEP_HI:`POF_CTRL_DEP_LO] = depth;       // [R7]
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q       <= `POF_CTRL_RESET;
      roi_q        <= `POF_ROI_RESET;
      sel_q        <= `POF_SEL_SENSOR;
      sens_ch_q    <= `POF_PAT_OFF;
      pipe_ch_q    <= `POF_PAT_OFF;
      aw_got_q     <= 1'b0;
      w_got_q      <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `POF_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q  <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q  <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `POF_RESP_OKAY;
        case (aw_addr_q)
          `POF_OFS_CTRL: begin
            ctrl_q <= ctrl_d;
          end
          `POF_OFS_ROI: begin
            roi_q <= merge(roi_q, w_data_q, w_strb_q);
          end
          `POF_OFS_PATTERN: begin
            if (w_strb_q[0]) begin
              sel_q <= w_data_q[`POF_PAT_SEL];                 // [R8]
              // choice goes to the generator the new select names
              if (w_data_q[`POF_PAT_SEL] == `POF_SEL_SENSOR) begin
                if (wr_ch == `POF_PAT_OFF ||
                    wr_ch == `POF_PAT_SENSOR) begin
                  sens_ch_q <= wr_ch;                          // [R9] [R10]
                end
              end else if (wr_ch != `POF_PAT_SENSOR) begin
                pipe_ch_q <= wr_ch;                            // [R9]
              end
            end
          end
          `POF_OFS_STATUS: begin
          end
          default: begin
            s_axi_bresp <= `POF_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  always @* begin
    rd_ok = 1'b1;
    rd_d  = 32'h0000_0000;
    case (s_axi_araddr)
      `POF_OFS_CTRL: begin
        rd_d[8:0] = ctrl_q[8:0];
      end
      `POF_OFS_PATTERN: begin
        rd_d[`POF_PAT_SEL] = sel_q;
        rd_d[`POF_PAT_CH_HI:`POF_PAT_CH_LO] =
          (sel_q == `POF_SEL_SENSOR) ? sens_ch_q : pipe_ch_q;
      end
      `POF_OFS_ROI: begin
        rd_d = roi_q;
      end
      `POF_OFS_STATUS: begin
        rd_d[0]    = acq_en;
        rd_d[1]    = sens_on;
        rd_d[2]    = pipe_on;
        rd_d[3]    = !sens_on && !pipe_on;                     // [R16]
        rd_d[5:4]  = rep_order;                                // [R18]
        rd_d[6]    = state_q;
        rd_d[15:8] = frame_q;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `POF_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_d;
      s_axi_rresp  <= rd_ok ? `POF_RESP_OKAY : `POF_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // pipeline-start pattern generator
  // ------------------------------------------------------------
  reg  [7:0]       inc_q;
  wire [7:0]       frm;
  wire             take;
  wire [7:0]       inc_val;
  wire [7:0]       grey;
  wire [MEM_W-1:0] in_word;

  assign take    = pix_valid && pix_ready;
  // count parks at all-ones while stopped, so the first frame is zero
  assign frm     = frame_q + {7'h00, pix_sof};
  assign inc_val = pix_sof ? 8'h00 : inc_q;                    // [R19]
  assign grey    = (pipe_ch_q == `POF_PAT_VARY) ?
                   (inc_val ^ frm) : inc_val;                  // [R12]
  // injected ahead of formatting so all later stages still act on it;
  // exposure and gain live upstream and never reach this path
  assign in_word = pipe_on ?
                   {grey_to_raw(grey, depth), grey, grey, grey} // [R13] [R14]
                 : {pix_sample, pix_rgb};                      // [R16]

  always @(posedge aclk) begin
    if (!aresetn) begin
      inc_q   <= 8'h00;
      frame_q <= 8'hFF;
    end else begin
      if (!acq_en) begin
        frame_q <= 8'hFF;                                      // [R12]
      end else if (take) begin
        frame_q <= frm;
      end
      if (take) begin
        inc_q <= inc_val + 8'h01;                              // [R11]
      end
    end
  end

  // ------------------------------------------------------------
  // line buffer, mirror and crop
  // ------------------------------------------------------------
  reg  [MEM_W-1:0] line_mem [0:MAX_W-1];
  reg  [IDX_W-1:0] wr_idx_q;
  reg  [IDX_W:0]   len_q;
  reg  [IDX_W-1:0] k_q;
  reg              sof_pend_q;
  reg              sof_line_q;
  wire [IDX_W-1:0] rd_idx;
  wire [MEM_W-1:0] rd_word;
  wire [15:0]      roi_x;
  wire [16:0]      roi_end;
  wire             in_roi;
  wire             last_k;
  wire             last_out;
  wire             fifo_rdy;
  wire             advance;
  wire [15:0]      phase;

  assign pix_ready = acq_en && (state_q == ST_FILL);
  assign roi_x     = roi_q[`POF_ROI_X_HI:`POF_ROI_X_LO];
  assign roi_end   = {1'b0, roi_x} + {1'b0, roi_q[`POF_ROI_W_HI:`POF_ROI_W_LO]};
  assign rd_idx    = mirror_en ? (len_q[IDX_W-1:0] - 1'b1 - k_q) : k_q; // [R17]
  assign rd_word   = line_mem[rd_idx];
  // crop counts output positions, i.e. after the flip
  assign in_roi    = ({6'h00, k_q} >= roi_x) &&
                     ({7'h00, k_q} < roi_end);                 // [R17]
  assign last_k    = ({1'b0, k_q} == len_q - 1'b1);
  assign last_out  = last_k || ({7'h00, k_q} == roi_end - 1'b1);
  assign advance   = (state_q == ST_DRAIN) && (!in_roi || fifo_rdy);
  assign phase     = {6'h00, k_q} - roi_x;

  always @(posedge aclk) begin
    if (take) begin
      line_mem[wr_idx_q] <= in_word;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q    <= ST_FILL;
      wr_idx_q   <= {IDX_W{1'b0}};
      len_q      <= {(IDX_W+1){1'b0}};
      k_q        <= {IDX_W{1'b0}};
      sof_pend_q <= 1'b0;
      sof_line_q <= 1'b0;
    end else begin
      case (state_q)
        ST_FILL: begin
          if (take) begin
            if (pix_sof) begin
              sof_pend_q <= 1'b1;
            end
            // overlong lines keep overwriting the final slot
            if (wr_idx_q != MAX_W[IDX_W-1:0] - 1'b1) begin
              wr_idx_q <= wr_idx_q + 1'b1;
            end
            if (pix_eol) begin
              len_q      <= {1'b0, wr_idx_q} + 1'b1;
              wr_idx_q   <= {IDX_W{1'b0}};
              k_q        <= {IDX_W{1'b0}};
              sof_line_q <= sof_pend_q || pix_sof;
              sof_pend_q <= 1'b0;
              state_q    <= ST_DRAIN;
            end
          end
        end
        ST_DRAIN: begin
          if (advance) begin
            if (in_roi) begin
              sof_line_q <= 1'b0;
            end
            k_q <= k_q + 1'b1;
            if (last_k) begin
              state_q <= ST_FILL;
            end
          end
        end
        default: begin
          state_q <= ST_FILL;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // format conversion
  // ------------------------------------------------------------
  wire signed [17:0] r_s;
  wire signed [17:0] g_s;
  wire signed [17:0] b_s;
  wire signed [17:0] y_s;
  wire signed [17:0] cb_s;
  wire signed [17:0] cr_s;
  wire [7:0]         y8;
  wire [7:0]         cb8;
  wire [7:0]         cr8;
  wire [15:0]        word16;
  reg  [24:0]        fmt_d;

  assign r_s  = {10'h000, rd_word[23:16]};
  assign g_s  = {10'h000, rd_word[15:8]};
  assign b_s  = {10'h000, rd_word[7:0]};
  // weights sum to 256: no overflow
  assign y_s  = (18'sd77 * r_s + 18'sd150 * g_s + 18'sd29 * b_s) >>> 8;
  assign cb_s = ((18'sd128 * b_s - 18'sd43 * r_s - 18'sd85 * g_s) >>> 8)
                + 18'sd128;
  assign cr_s = ((18'sd128 * r_s - 18'sd107 * g_s - 18'sd21 * b_s) >>> 8)
                + 18'sd128;
  assign y8   = clip8(y_s);                                    // [R1]
  assign cb8  = clip8(cb_s);
  assign cr8  = clip8(cr_s);
  assign word16 = left_align(rd_word[MEM_W-1:24], depth);      // [R5] [R6]

  // bit 24 flags a word that carries chroma
  always @* begin
    fmt_d = 25'h0000000;
    case (fmt)
      `POF_FMT_RAW16: begin
        fmt_d[15:0] = word16;                                  // [R5]
      end
      `POF_FMT_RAW8: begin
        fmt_d[7:0] = word16[15:8];                             // [R4]
      end
      `POF_FMT_444: begin
        fmt_d = {1'b1, cr8, cb8, y8};                          // [R1]
      end
      `POF_FMT_422: begin
        fmt_d[7:0] = y8;
        if (!phase[0]) begin
          fmt_d[24:8] = {1'b1, cr8, cb8};                      // [R2]
        end
      end
      `POF_FMT_411: begin
        fmt_d[7:0] = y8;
        if (phase[1:0] == 2'h0) begin
          fmt_d[24:8] = {1'b1, cr8, cb8};                      // [R3]
        end
      end
      default: begin
        fmt_d[15:0] = word16;
      end
    endcase
  end

  // ------------------------------------------------------------
  // output buffering
  // ------------------------------------------------------------
  wire [26:0] fifo_out;

  pof_fifo #(
    .WIDTH (27),
    .DEPTH (FIFO_D),
    .AW    (FIFO_A)
  ) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  ((state_q == ST_DRAIN) && in_roi),
    .in_ready  (fifo_rdy),
    .in_data   ({sof_line_q, last_out, fmt_d}),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (fifo_out)
  );

  assign out_sof  = fifo_out[26];
  assign out_eol  = fifo_out[25];
  assign out_data = fifo_out[24:0];
endmodule // pof_top

`default_nettype wire

// ### shared/pof_defs.vh
`ifndef POF_DEFS_VH
`define POF_DEFS_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define POF_OFS_CTRL      8'h00
`define POF_OFS_PATTERN   8'h04
`define POF_OFS_ROI       8'h08
`define POF_OFS_STATUS    8'h0C

// ------------------------------------------------------------
// control fields
// ------------------------------------------------------------
`define POF_CTRL_ACQ      0
`define POF_CTRL_MIRROR   1
`define POF_CTRL_FMT_LO   2
`define POF_CTRL_FMT_HI   4
`define POF_CTRL_DEP_LO   5
`define POF_CTRL_DEP_HI   6
`define POF_CTRL_ORD_LO   7
`define POF_CTRL_ORD_HI   8
`define POF_CTRL_RESET    32'h0000_0000

// ------------------------------------------------------------
// pattern fields and choices
// ------------------------------------------------------------
`define POF_PAT_SEL       0
`define POF_PAT_CH_LO     4
`define POF_PAT_CH_HI     5
`define POF_SEL_SENSOR    1'b0
`define POF_SEL_PIPE      1'b1
`define POF_PAT_OFF       2'h0
`define POF_PAT_SENSOR    2'h1
`define POF_PAT_INCR      2'h2
`define POF_PAT_VARY      2'h3

// ------------------------------------------------------------
// region of interest fields
// ------------------------------------------------------------
`define POF_ROI_X_LO      0
`define POF_ROI_X_HI      15
`define POF_ROI_W_LO      16
`define POF_ROI_W_HI      31
`define POF_ROI_RESET     32'hFFFF_0000

// ------------------------------------------------------------
// output formats, converter depths, mosaic orders
// ------------------------------------------------------------
`define POF_FMT_RAW16     3'h0
`define POF_FMT_RAW8      3'h1
`define POF_FMT_444       3'h2
`define POF_FMT_422       3'h3
`define POF_FMT_411       3'h4
`define POF_DEP_10        2'h0
`define POF_DEP_12        2'h1
`define POF_DEP_14        2'h2
`define POF_ORD_RG        2'h0
`define POF_ORD_GR        2'h1
`define POF_ORD_GB        2'h2
`define POF_ORD_BG        2'h3

// ------------------------------------------------------------
// bus responses
// ------------------------------------------------------------
`define POF_RESP_OKAY     2'h0
`define POF_RESP_SLVERR   2'h2

`endif

// ### verif/pof_sink.sv
`default_nettype none
// ------------------------------------------------------------
// downstream pipeline
// ------------------------------------------------------------
module pof_sink (
  input  wire logic        aclk,
  input  wire logic        stall,
  input  wire logic        out_valid,
  output var  logic        out_ready,
  input  wire logic [26:0] out_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [26:0] q[$];
  initial out_ready = 1'b0;
  // every other cycle refused so the fifo really backs up
  always @(posedge aclk) begin
    out_ready <= stall ? !out_ready : 1'b1;
    if (out_valid && out_ready) q.push_back(out_data);
  end
endmodule // pof_sink
`default_nettype wire

// ### verif/pof_chk.sv
`default_nettype none
module pof_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        pix_valid,
  input wire logic        pix_ready,
  input wire logic        pix_eol,
  input wire logic        sensor_tp_enable,
  input wire logic        out_valid,
  input wire logic        out_ready,
  input wire logic [24:0] out_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  r_latency_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  b_latency_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  busy_refuse_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  ar_gate_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  out_hold_a: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_data)) else $error("output word dropped");
  line_drain_a: assert property (pix_valid && pix_ready && pix_eol |=>
    !pix_ready) else $error("line not drained");
  reset_idle_a: assert property ($rose(aresetn) |->
    !out_valid && !sensor_tp_enable && !s_axi_bvalid)
    else $error("outputs busy after reset");
endmodule // pof_chk
bind pof_top pof_chk u_pof_chk (.*);
`default_nettype wire

// ### verif/pof_top_tb.sv
`include "pof_defs.vh"
`default_nettype none
module pof_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] OK = `POF_RESP_OKAY;
  localparam logic [1:0] ERR = `POF_RESP_SLVERR;
  logic aclk, aresetn, pix_valid, pix_sof, pix_eol, stall, out_ready;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, pix_ready, sensor_tp_enable;
  logic out_valid, out_sof, out_eol;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [13:0] pix_sample;
  logic [23:0] pix_rgb;
  logic [24:0] out_data;
  logic [13:0] smp[$];
  logic [24:0] exq[$];
  logic [15:0] mx[3] = '{16'hFFC0, 16'hFFF0, 16'hFFFC};
  int fails, cmp_count, cyc, d, i;

  pof_top #(.ADC_W(14)) u_pof_top (.*);
  pof_sink u_pof_sink (.aclk, .stall, .out_valid, .out_ready,
    .out_data({out_sof, out_eol, out_data}));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dt,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    cmp(s_axi_bresp, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    v = s_axi_rdata;
    cmp(s_axi_rresp, er);
  endtask

  // acquisition goes off before the depth may change
  task automatic cfg(input logic mir, input logic [2:0] fmt,
                     input logic [1:0] dep);
    wr(`POF_OFS_CTRL, 32'h0, OK);
    wr(`POF_OFS_CTRL, {dep, fmt, mir, 1'b0}, OK);
    wr(`POF_OFS_CTRL, {dep, fmt, mir, 1'b1}, OK);
  endtask

  task automatic run_line(input logic sof);
    @(posedge aclk);
    foreach (smp[k]) begin
      pix_valid <= 1'b1;
      pix_sample <= smp[k];
      pix_sof <= sof && k == 0;
      pix_eol <= k == smp.size() - 1;
      do @(posedge aclk); while (!pix_ready);
    end
    pix_valid <= 1'b0;
    while (u_pof_sink.q.size() < exq.size()) @(posedge aclk);
    foreach (exq[k]) cmp(u_pof_sink.q.pop_front(),
      {sof && k == 0, k == exq.size() - 1, exq[k]});
    smp.delete();
    exq.delete();
  endtask

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      $display("ERROR %0t: timeout", $time);
      test_done();
    end
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    {aresetn, pix_valid, pix_sof, pix_eol, stall} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, pix_sample} = '0;
    s_axi_wstrb = 4'hF;
    pix_rgb = 24'hFFFFFF;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`POF_OFS_CTRL, OK);
    cmp(v, `POF_CTRL_RESET);
    rd(`POF_OFS_ROI, OK);
    cmp(v, `POF_ROI_RESET);
    rd(8'h10, ERR);
    cmp(v, 32'h0);
    wr(8'h10, 32'h5A, ERR);
    $display("test registers done");
    wr(`POF_OFS_PATTERN, 32'h10, OK);
    cmp(sensor_tp_enable, 1);
    wr(`POF_OFS_PATTERN, 32'h20, OK);
    cmp(sensor_tp_enable, 1);
    rd(`POF_OFS_STATUS, OK);
    cmp(v[3], 0);
    wr(`POF_OFS_PATTERN, 32'h00, OK);
    cmp(sensor_tp_enable, 0);
    rd(`POF_OFS_STATUS, OK);
    cmp(v[3], 1);
    $display("test selector done");
    for (d = 0; d < 3; d++) begin
      cfg(1'b0, `POF_FMT_RAW16, d[1:0]);
      smp = '{14'h3FFF >> (4 - 2 * d), 14'h1};
      exq = '{mx[d], 25'd1 << (6 - 2 * d)};
      run_line(1'b1);
    end
    cfg(1'b0, `POF_FMT_RAW8, `POF_DEP_14);
    smp = '{14'h3FFF, 14'h1234};
    exq = '{25'hFF, 25'h48};
    run_line(1'b1);
    $display("test depth done");
    cfg(1'b1, `POF_FMT_RAW16, `POF_DEP_14);
    smp = '{1, 2, 3, 4};
    exq = '{16, 12, 8, 4};
    run_line(1'b1);
    rd(`POF_OFS_STATUS, OK);
    cmp(v[5:4], `POF_ORD_GR);
    wr(`POF_OFS_ROI, {16'd2, 16'd1}, OK);
    smp = '{1, 2, 3, 4};
    exq = '{12, 8};
    run_line(1'b1);
    wr(`POF_OFS_ROI, `POF_ROI_RESET, OK);
    $display("test mirror done");
    wr(`POF_OFS_PATTERN, 32'h10, OK);
    wr(`POF_OFS_PATTERN, 32'h21, OK);
    cfg(1'b0, `POF_FMT_RAW8, `POF_DEP_14);
    stall <= 1'b1;
    for (i = 0; i < 258; i++) begin
      smp.push_back(14'(i) ^ 14'h155);
      exq.push_back(25'(i[7:0]));
    end
    run_line(1'b1);
    smp = '{7, 7, 7};
    exq = '{0, 1, 2};
    run_line(1'b1);
    wr(`POF_OFS_PATTERN, 32'h31, OK);
    for (i = 0; i < 3; i++) begin
      if (i != 1) cfg(1'b0, `POF_FMT_RAW8, `POF_DEP_14);
      smp = '{7, 7};
      exq = '{i % 2, 1 - i % 2};
      run_line(1'b1);
    end
    stall <= 1'b0;
    wr(`POF_OFS_PATTERN, 32'h01, OK);
    wr(`POF_OFS_PATTERN, 32'h00, OK);
    $display("test pattern done");
    for (d = 0; d < 3; d++) begin
      cfg(1'b0, 3'(`POF_FMT_444 + d), `POF_DEP_14);
      for (i = 0; i < 4; i++) begin
        smp.push_back(14'h0);
        exq.push_back(i % (1 << d) == 0 ? 25'h18080FF : 25'hFF);
      end
      run_line(1'b1);
    end
    $display("test chroma done");
    test_done();
  end
endmodule // pof_top_tb
`default_nettype wire
